// ---- hw/aofp_coder.sv ----
// Saturation, over-range detection and output coding of one sample.
`timescale 1ns/1ps
module aofp_coder
  import aofp_pkg::*;
#(
  parameter int W = 10,
  parameter int RW = 12
)
(
  input wire logic [RW-1:0] raw,
  input wire aofp_fmt_t fmt,
  output logic [W-1:0] bin,
  output logic [W-1:0] word,
  output logic over
);
  localparam logic [RW-1:0] FULL = RW'((1 << W) - 1);
  // Codes past full scale clamp instead of wrapping.
  assign over = raw >= FULL;
  assign bin = over ? FULL[W-1:0] : raw[W-1:0];
  assign word = (fmt == FMT_TC) ? {~bin[W-1], bin[W-2:0]}
              : (fmt == FMT_GRAY) ? (bin ^ (bin >> 1))
              : bin;
endmodule

// ---- hw/aofp_top.sv ----
// Output format, clock divide, over-range and power state control of the converter.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "aofp_cfg.svh"
// What this block does
// - Divider strap: ground divides clock by two, floating by one; supply forbidden.
// - A serial divider setting beats the divider strap.
// - Samples leave on a parallel double-data-rate bus in every output mode.
// - Mode strap: ground single-ended, floating differential 3mA, supply differential 2mA.
// - A serial output mode setting beats the mode strap.
// - Over-range flag rises when the code reaches positive full scale, every sample.
// - Over-range codes hold at full scale and never wrap.
// - Normal operation returns about 1us after nap, 1ms after sleep.
// - Select low through sleep keeps registers alive; the 1ms wake still applies.
// - Nap or sleep puts data, forwarded clock and over-range outputs in high impedance.
// - A stopped clock during nap stretches recovery by up to 52us relock.
// - Power strap at power-on: ground normal, floating sleep, supply nap.
// - Serial power setting overrides strap per core; strap acts on the whole device.
// - Format strap: ground offset binary, floating two's complement, supply Gray.
// - A serial format setting beats the format strap.
// - Offset binary runs from all zeros to all ones, monotonic.
// - Two's complement is offset binary with its top bit inverted.
// - Gray keeps the top bit; each lower bit is XOR with the next higher.
// - Mid-scale gives 1000000000, 0000000000 and 1100000000 respectively.
// - Each sample leaves fifteen sample clocks after its conversion starts.
// - The two cores take alternate sample clocks, doubling the stream rate.
module aofp_top
  import aofp_pkg::*;
#(
  parameter int W = `AOFP_WIDTH,
  parameter int RW = `AOFP_RAW_W,
  parameter int LAT = `AOFP_LATENCY,
  parameter int SLEEP_CYC = `AOFP_SLEEP_US * `AOFP_CLK_MHZ,
  parameter int RELOCK_CYC = `AOFP_RELOCK_US * `AOFP_CLK_MHZ,
  parameter int SETUP_CYC = `AOFP_SETUP_US * `AOFP_CLK_MHZ
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [1:0] clock_divide_strap,
  input wire logic [1:0] output_mode_strap,
  input wire logic [1:0] power_state_strap,
  input wire logic [1:0] output_format_strap,
  input wire logic serial_select_n,
  input wire logic input_clock_lost,
  input wire logic [RW-1:0] core0_code,
  input wire logic [RW-1:0] core1_code,
  output logic [W-1:0] sample_data,
  output logic over_range,
  output logic forwarded_output_clock,
  output logic outputs_oe_b,
  output logic cmos_mode,
  output logic drive_2ma,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NAP_CYC = (`AOFP_NAP_NS * `AOFP_CLK_MHZ) / 1000;
  localparam logic [RW-1:0] FULL = RW'((1 << W) - 1);

  // ==========================================================
  // Pin synchronisers and strap capture
  logic [9:0] sync1_q, sync2_q;
  logic [1:0] cap_q;
  logic div2_strap_q, strap_err_q;
  aofp_mode_t mode_strap_q;
  aofp_fmt_t fmt_strap_q;
  aofp_pwr_t pwr_strap_q;
  aofp_strap_t div_s, mode_s, pwr_s, fmt_s;
  logic sel_hi, clk_lost;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end
    else
    begin
      sync1_q <= {input_clock_lost, serial_select_n, output_format_strap,
                  power_state_strap, output_mode_strap, clock_divide_strap};
      sync2_q <= sync1_q;
    end
  end

  assign div_s = aofp_strap_t'(sync2_q[1:0]);
  assign mode_s = aofp_strap_t'(sync2_q[3:2]);
  assign pwr_s = aofp_strap_t'(sync2_q[5:4]);
  assign fmt_s = aofp_strap_t'(sync2_q[7:6]);
  assign sel_hi = sync2_q[8];
  assign clk_lost = sync2_q[9];

  // Straps are caught once, after the synchronisers have filled following reset.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cap_q <= 2'h0;
      div2_strap_q <= 1'b0;
      strap_err_q <= 1'b0;
      mode_strap_q <= MODE_DIFF3;
      fmt_strap_q <= FMT_TC;
      pwr_strap_q <= PWR_NORMAL;
    end
    else if (cap_q != 2'h3)
    begin
      cap_q <= cap_q + 2'h1;
      if (cap_q == 2'h2)
      begin
        div2_strap_q <= div_s == STRAP_GND;
        strap_err_q <= div_s == STRAP_SUPPLY;
        mode_strap_q <= (mode_s == STRAP_GND) ? MODE_CMOS
                      : (mode_s == STRAP_SUPPLY) ? MODE_DIFF2 : MODE_DIFF3;
        fmt_strap_q <= (fmt_s == STRAP_GND) ? FMT_OB
                     : (fmt_s == STRAP_SUPPLY) ? FMT_GRAY : FMT_TC;
        pwr_strap_q <= (pwr_s == STRAP_GND) ? PWR_NORMAL
                     : (pwr_s == STRAP_SUPPLY) ? PWR_NAP : PWR_SLEEP;
      end
    end
  end

  // ==========================================================
  // Effective settings
  logic [7:0] ctrl_q;
  logic [5:0] pwr_q;
  logic div2;
  aofp_mode_t mode_e;
  aofp_fmt_t fmt_e;
  aofp_pwr_t core0_p, core1_p, tgt;

  assign div2 = ctrl_q[`AOFP_DIV_OVR] ? ctrl_q[`AOFP_DIV_BY2] : div2_strap_q;
  assign mode_e = ctrl_q[`AOFP_MODE_OVR] ?
                  aofp_mode_t'(ctrl_q[`AOFP_MODE_LSB+:2]) : mode_strap_q;
  assign fmt_e = ctrl_q[`AOFP_FMT_OVR] ?
                 aofp_fmt_t'(ctrl_q[`AOFP_FMT_LSB+:2]) : fmt_strap_q;
  // Each core may be overridden alone; the device sleeps as deep as its deepest core.
  assign core0_p = pwr_q[0] ? aofp_pwr_t'(pwr_q[2:1]) : pwr_strap_q;
  assign core1_p = pwr_q[`AOFP_PWR_STRIDE] ?
                   aofp_pwr_t'(pwr_q[`AOFP_PWR_STRIDE+1+:2]) : pwr_strap_q;
  assign tgt = (core0_p == PWR_SLEEP || core1_p == PWR_SLEEP) ? PWR_SLEEP
             : (core0_p == PWR_NAP || core1_p == PWR_NAP) ? PWR_NAP : PWR_NORMAL;

  // ==========================================================
  // Power state machine
  aofp_ps_t ps_q, ps_d;
  logic [17:0] wcnt_q, wcnt_d, scnt_q;
  logic lost_seen_q, regs_live_q, out_on;

  always_comb
  begin
    ps_d = ps_q;
    wcnt_d = (wcnt_q != 18'h0) ? wcnt_q - 18'h1 : wcnt_q;
    case (ps_q)
      PS_RUN:
        if (tgt == PWR_SLEEP)
          ps_d = PS_SLEEP;
        else if (tgt == PWR_NAP)
          ps_d = PS_NAP;
      PS_NAP, PS_SLEEP:
        if (tgt == PWR_SLEEP)
          ps_d = PS_SLEEP;
        else if (tgt == PWR_NAP)
          ps_d = PS_NAP;
        else
        begin
          ps_d = PS_WAKE;
          if (ps_q == PS_SLEEP)
            wcnt_d = 18'(SLEEP_CYC);
          else if (lost_seen_q)
            wcnt_d = 18'(NAP_CYC + RELOCK_CYC);
          else
            wcnt_d = 18'(NAP_CYC);
        end
      PS_WAKE:
        if (tgt == PWR_SLEEP)
          ps_d = PS_SLEEP;
        else if (tgt == PWR_NAP)
          ps_d = PS_NAP;
        else if (wcnt_q <= 18'h1)
          ps_d = PS_RUN;
      default:
        ps_d = PS_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ps_q <= PS_RUN;
      wcnt_q <= 18'h0;
      lost_seen_q <= 1'b0;
    end
    else
    begin
      ps_q <= ps_d;
      wcnt_q <= wcnt_d;
      if (ps_q == PS_NAP && clk_lost)
        lost_seen_q <= 1'b1;
      else if (ps_q == PS_RUN)
        lost_seen_q <= 1'b0;
    end
  end

  // Registers lose power in sleep with select high and need a setup wait once it drops.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      regs_live_q <= 1'b1;
      scnt_q <= 18'h0;
    end
    else if (ps_q != PS_SLEEP || (regs_live_q && !sel_hi))
    begin
      regs_live_q <= 1'b1;
      scnt_q <= 18'h0;
    end
    else if (sel_hi)
    begin
      regs_live_q <= 1'b0;
      scnt_q <= 18'h0;
    end
    else
    begin
      scnt_q <= scnt_q + 18'h1;
      regs_live_q <= scnt_q >= 18'(SETUP_CYC - 1);
    end
  end

  // ==========================================================
  // Sample path
  logic div_ph_q, core_sel_q, sample_en;
  logic [RW-1:0] pipe_q [0:LAT-1];
  logic [RW-1:0] entry;
  logic [W-1:0] cod_bin, cod_word;
  logic cod_over;
  logic [W-1:0] data_q;
  logic or_q, fclk_q, oe_b_q, cmos_q, drv_q;

  assign sample_en = div2 ? div_ph_q : 1'b1;
  assign entry = core_sel_q ? core1_code : core0_code;
  assign out_on = ps_q == PS_RUN;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      div_ph_q <= 1'b0;
      core_sel_q <= 1'b0;
    end
    else
    begin
      div_ph_q <= ~div_ph_q;
      if (sample_en)
        core_sel_q <= ~core_sel_q;
    end
  end

  // The delay line carries raw codes so a format change acts on the next word out.
  always_ff @(posedge clock)
  begin
    if (sample_en)
    begin
      pipe_q[0] <= entry;
      for (int i = 1; i < LAT; i++)
        pipe_q[i] <= pipe_q[i-1];
    end
  end

  aofp_coder #(.W(W), .RW(RW)) u_coder (
    .raw(pipe_q[LAT-1]),
    .fmt(fmt_e),
    .bin(cod_bin),
    .word(cod_word),
    .over(cod_over)
  );

  // Each forwarded clock edge, rising or falling, marks a new word on the bus.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      data_q <= '0;
      or_q <= 1'b0;
      fclk_q <= 1'b0;
      oe_b_q <= 1'b1;
      cmos_q <= 1'b0;
      drv_q <= 1'b0;
    end
    else
    begin
      oe_b_q <= ~out_on;
      cmos_q <= mode_e == MODE_CMOS;
      drv_q <= mode_e == MODE_DIFF2;
      if (!out_on)
      begin
        data_q <= '0;
        or_q <= 1'b0;
        fclk_q <= 1'b0;
      end
      else if (sample_en)
      begin
        data_q <= cod_word;
        or_q <= cod_over;
        fclk_q <= ~fclk_q;
      end
    end
  end

  assign sample_data = data_q;
  assign over_range = or_q;
  assign forwarded_output_clock = fclk_q;
  assign outputs_oe_b = oe_b_q;
  assign cmos_mode = cmos_q;
  assign drive_2ma = drv_q;

  // ==========================================================
  // Register bus slave
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, wmask, stat, rd_mux;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_wr, wa_ctrl, wa_pwr, wa_stat, ra_ctrl, ra_pwr, ra_stat, ra_ok, wr_ok;

  assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
  assign wa_ctrl = {awaddr_q[7:2], 2'h0} == `AOFP_ADDR_CTRL;
  assign wa_pwr = {awaddr_q[7:2], 2'h0} == `AOFP_ADDR_PWR;
  assign wa_stat = {awaddr_q[7:2], 2'h0} == `AOFP_ADDR_STAT;
  assign wr_ok = regs_live_q && (wa_ctrl || wa_pwr || wa_stat);
  assign ra_ctrl = {s_axi_araddr[7:2], 2'h0} == `AOFP_ADDR_CTRL;
  assign ra_pwr = {s_axi_araddr[7:2], 2'h0} == `AOFP_ADDR_PWR;
  assign ra_stat = {s_axi_araddr[7:2], 2'h0} == `AOFP_ADDR_STAT;
  assign ra_ok = regs_live_q && (ra_ctrl || ra_pwr || ra_stat);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign stat = {18'h0, tgt, lost_seen_q, strap_err_q, regs_live_q, ps_q, fmt_e,
                 mode_e, div2};
  assign rd_mux = !ra_ok ? 32'h0 : ra_ctrl ? {24'h0, ctrl_q}
                : ra_pwr ? {26'h0, pwr_q} : stat;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `AOFP_CTRL_RST;
      pwr_q <= `AOFP_PWR_RST;
    end
    else if (do_wr && wr_ok)
    begin
      if (wa_ctrl)
        ctrl_q <= (ctrl_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
      if (wa_pwr)
        pwr_q <= (pwr_q & ~wmask[5:0]) | (wdata_q[5:0] & wmask[5:0]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `AOFP_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (do_wr)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `AOFP_RESP_OKAY : `AOFP_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `AOFP_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= ra_ok ? `AOFP_RESP_OKAY : `AOFP_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // Checks
  logic [4:0] run1_q;
  always_ff @(posedge clock)
  begin
    if (!rst_b || div2)
      run1_q <= 5'h0;
    else if (run1_q != 5'h1f)
      run1_q <= run1_q + 5'h1;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  AST_DIV_STRAP: assert property (cap_q == 2'h2 |=> div2_strap_q == ($past(div_s) == STRAP_GND))
    else $error("divider strap mapped wrongly");
  AST_DIV_OVR: assert property (ctrl_q[`AOFP_DIV_OVR] && ctrl_q[`AOFP_DIV_BY2] && sample_en
    |=> !sample_en)
    else $error("serial divide by two not honoured");
  AST_DDR: assert property (out_on && sample_en |=> $changed(fclk_q))
    else $error("forwarded clock missed a sample edge");
  AST_MODE_OVR: assert property (ctrl_q[`AOFP_MODE_OVR] && ctrl_q[`AOFP_MODE_LSB+:2] == 2'h2
    |=> drv_q && !cmos_q)
    else $error("serial output mode not honoured");
  AST_SAT: assert property (out_on && sample_en && pipe_q[LAT-1] >= FULL && fmt_e == FMT_OB
    |=> or_q && data_q == FULL[W-1:0])
    else $error("over-range sample not clamped and flagged");
  AST_GRAY_MID: assert property (fmt_e == FMT_GRAY && pipe_q[LAT-1] == 12'h200
    |-> cod_word == 10'h300)
    else $error("gray mid-scale code wrong");
  AST_TC: assert property (fmt_e == FMT_TC |-> cod_word == {~cod_bin[W-1], cod_bin[W-2:0]})
    else $error("two's complement code wrong");
  AST_LAT: assert property (run1_q > 5'(LAT) |-> pipe_q[LAT-1] == $past(entry, LAT))
    else $error("sample latency wrong");
  AST_HIZ: assert property (!out_on |=> oe_b_q && !fclk_q)
    else $error("outputs driven while powered down");
  AST_NAP_WAKE: assert property (ps_q == PS_NAP && tgt == PWR_NORMAL && !lost_seen_q
    |=> ps_q == PS_WAKE && wcnt_q == 18'(NAP_CYC))
    else $error("nap recovery time wrong");
  AST_RELOCK: assert property (ps_q == PS_NAP && tgt == PWR_NORMAL && lost_seen_q
    |=> wcnt_q == 18'(NAP_CYC + RELOCK_CYC))
    else $error("relock extension missing");
  AST_WAKE_HOLD: assert property (ps_q == PS_WAKE && wcnt_q > 18'h1 |=> ps_q != PS_RUN)
    else $error("woke early");
  AST_REGS_SLEEP: assert property (ps_q == PS_SLEEP && sel_hi |=> !regs_live_q)
    else $error("registers live in sleep with select high");
  AST_CORE_ALT: assert property (sample_en |=> $changed(core_sel_q))
    else $error("cores not alternating");

  COV_WAKE: cover property (ps_q == PS_WAKE ##1 ps_q == PS_RUN);
  COV_SAT: cover property (out_on && sample_en && cod_over);
  COV_GRAY: cover property (fmt_e == FMT_GRAY && out_on && sample_en);
  COV_REFUSED: cover property (do_wr && !wr_ok);
endmodule

// ---- pkg/aofp_cfg.svh ----
// Offsets, field positions, reset values and timing figures of the control block.
`ifndef AOFP_CFG_SVH
`define AOFP_CFG_SVH
// ==========================================================
// Timing
`define AOFP_CLK_MHZ 200
`define AOFP_NAP_NS 1000
`define AOFP_SLEEP_US 1000
`define AOFP_RELOCK_US 52
`define AOFP_SETUP_US 150
`define AOFP_LATENCY 15
// ==========================================================
// Sample word
`define AOFP_WIDTH 10
`define AOFP_RAW_W 12
// ==========================================================
// Register map
`define AOFP_ADDR_CTRL 8'h00
`define AOFP_ADDR_PWR 8'h04
`define AOFP_ADDR_STAT 8'h08
`define AOFP_DIV_OVR 0
`define AOFP_DIV_BY2 1
`define AOFP_MODE_OVR 2
`define AOFP_MODE_LSB 3
`define AOFP_FMT_OVR 5
`define AOFP_FMT_LSB 6
`define AOFP_PWR_STRIDE 3
`define AOFP_CTRL_RST 8'h00
`define AOFP_PWR_RST 6'h00
`define AOFP_RESP_OKAY 2'h0
`define AOFP_RESP_SLVERR 2'h2
`endif

// ---- pkg/aofp_pkg.sv ----
// Types shared by the control block and its sample coder.
package aofp_pkg;
  typedef enum logic [1:0] {STRAP_GND = 2'h0, STRAP_FLOAT = 2'h1, STRAP_SUPPLY = 2'h2} aofp_strap_t;
  typedef enum logic [1:0] {MODE_CMOS = 2'h0, MODE_DIFF3 = 2'h1, MODE_DIFF2 = 2'h2} aofp_mode_t;
  typedef enum logic [1:0] {FMT_OB = 2'h0, FMT_TC = 2'h1, FMT_GRAY = 2'h2} aofp_fmt_t;
  typedef enum logic [1:0] {PWR_NORMAL = 2'h0, PWR_NAP = 2'h1, PWR_SLEEP = 2'h2} aofp_pwr_t;
  typedef enum logic [3:0] {
    PS_RUN = 4'h1,
    PS_NAP = 4'h2,
    PS_SLEEP = 4'h4,
    PS_WAKE = 4'h8
  } aofp_ps_t;
endpackage

// ---- sim/aofp_rx_model.sv ----
// Receiver model that captures the double-data-rate sample bus.
`timescale 1ns/1ps
module aofp_rx_model
  import aofp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [9:0] sample_data,
  input wire logic forwarded_output_clock,
  input wire logic outputs_oe_b,
  input wire logic gray,
  output logic [9:0] rx_word
);
  // ========
  // Capture
  // Both edges of the forwarded clock carry a word, so any change marks one.
  logic last_q;
  logic [9:0] word_q;
  function automatic logic [9:0] ungray(input logic [9:0] g);
    logic [9:0] b;
    b[9] = g[9];
    for (int i = 8; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction
  always_ff @(posedge clock)
  begin
    last_q <= forwarded_output_clock;
    if (!rst_b) word_q <= 10'h000;
    else if (!outputs_oe_b && forwarded_output_clock != last_q)
      word_q <= gray ? ungray(sample_data) : sample_data;
  end
  assign rx_word = word_q;
endmodule

// ---- sim/test_adc_output_format_power_ctrl.sv ----
// Self-checking bench of the converter output and power control block.
`timescale 1ns/1ps
module test_adc_output_format_power_ctrl
  import aofp_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] clock_divide_strap = 2'h1, output_mode_strap = 2'h1;
  logic [1:0] power_state_strap = 2'h0, output_format_strap = 2'h1;
  logic serial_select_n = 1'b1, input_clock_lost = 1'b0, rx_gray = 1'b0;
  logic [11:0] core0_code = 12'h000, core1_code = 12'h000;
  logic [9:0] sample_data, rx_word;
  logic over_range, forwarded_output_clock, outputs_oe_b, cmos_mode, drive_2ma;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] corner [6] = '{12'h000, 12'h200, 12'h3fe, 12'h3ff, 12'h400, 12'hfff};
  int failures = 0, n_compared = 0;
  aofp_top #(.SLEEP_CYC(40), .RELOCK_CYC(20), .SETUP_CYC(10)) i_dut (.clock, .rst_b,
    .clock_divide_strap, .output_mode_strap, .power_state_strap, .output_format_strap,
    .serial_select_n, .input_clock_lost, .core0_code, .core1_code, .sample_data,
    .over_range, .forwarded_output_clock, .outputs_oe_b, .cmos_mode, .drive_2ma,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  aofp_rx_model i_rx (.clock, .rst_b, .sample_data, .forwarded_output_clock,
    .outputs_oe_b, .gray(rx_gray), .rx_word);
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // ========
  // Tasks
  task automatic stop_test(input int extra);
    failures += extra;
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [9:0] enc(input logic [11:0] raw, input logic [1:0] f);
    logic [9:0] b;
    b = (raw >= 12'h3ff) ? 10'h3ff : raw[9:0];
    if (f == 2'h1) b = b ^ 10'h200;
    else if (f == 2'h2) b = b ^ (b >> 1);
    return b;
  endfunction
  task automatic reset(input logic [1:0] dv, md, pw, fm, input logic sel);
    @(posedge clock);
    clock_divide_strap <= dv;
    output_mode_strap <= md;
    power_state_strap <= pw;
    output_format_strap <= fm;
    serial_select_n <= sel;
    rst_b <= 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit k;
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    for (n = 0; n < 100 && !k; n++)
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k = s_axi_bvalid;
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    if (!k) stop_test(1);
    // Registered outputs follow the register one edge after the response edge.
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    bit k;
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    for (n = 0; n < 100 && !k; n++)
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    if (!k) stop_test(1);
  endtask
  task automatic run_stream(input logic [1:0] f);
    logic [11:0] h[$];
    logic [11:0] c;
    logic p;
    rx_gray <= (f == 2'h2);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clock);
      h.push_back(core0_code);
      c = (i % 4 == 0) ? corner[(i / 4) % 6] : 12'($urandom_range(1279));
      core0_code <= c;
      core1_code <= c;
      #1;
      if (i >= 32)
      begin
        check(sample_data, enc(h[i - 15], f));
        check(over_range, h[i - 15] >= 12'h3ff);
        check(forwarded_output_clock, !p);
        if (f == 2'h2) check(rx_word, enc(h[i - 16], 2'h0));
      end
      p = forwarded_output_clock;
    end
  endtask
  task automatic toggles(input int exp);
    int t;
    logic p;
    repeat (4) @(posedge clock);
    t = 0;
    p = forwarded_output_clock;
    repeat (40)
    begin
      @(posedge clock);
      if (forwarded_output_clock !== p) t++;
      p = forwarded_output_clock;
    end
    check(t, exp);
  endtask
  task automatic wake(input int lo, input int hi);
    int n;
    n = 0;
    while (outputs_oe_b !== 1'b0 && n < 500)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
    if (n == 500) stop_test(1);
  endtask
  // ========
  // Sequence
  initial
  begin
    void'($urandom(71));
    for (int s = 0; s < 3; s++)
    begin
      reset(2'h1, 2'(s), 2'h0, 2'(s), 1'b1);
      check({cmos_mode, drive_2ma}, {s == 0, s == 2});
      run_stream(2'(s));
    end
    for (int f = 0; f < 3; f++)
    begin
      wr(8'h00, 32'(f * 72 + 36));
      check(r, 2'h0);
      check({cmos_mode, drive_2ma}, {f == 0, f == 2});
      run_stream(2'(f));
    end
    wr(8'h00, 32'h3);
    toggles(20);
    rd(8'h08);
    check({r, d[0]}, 3'h1);
    rd(8'h0c);
    check(r, 2'h2);
    wr(8'h40, 32'h1);
    check(r, 2'h2);
    reset(2'h0, 2'h1, 2'h0, 2'h1, 1'b1);
    toggles(20);
    reset(2'h2, 2'h1, 2'h0, 2'h1, 1'b1);
    toggles(40);
    wr(8'h04, 32'h1b);
    repeat (10) @(posedge clock);
    check(outputs_oe_b, 1'b1);
    wr(8'h04, 32'h9);
    wake(195, 210);
    input_clock_lost <= 1'b1;
    wr(8'h04, 32'h1b);
    repeat (10) @(posedge clock);
    wr(8'h04, 32'h9);
    wake(215, 230);
    input_clock_lost <= 1'b0;
    reset(2'h1, 2'h1, 2'h1, 2'h1, 1'b1);
    check(outputs_oe_b, 1'b1);
    wr(8'h04, 32'h9);
    check(r, 2'h2);
    serial_select_n <= 1'b0;
    repeat (15) @(posedge clock);
    wr(8'h04, 32'h9);
    check(r, 2'h0);
    wake(38, 50);
    reset(2'h1, 2'h1, 2'h1, 2'h1, 1'b0);
    wr(8'h04, 32'h1);
    check(r, 2'h0);
    repeat (60) @(posedge clock);
    check(outputs_oe_b, 1'b1);
    wr(8'h04, 32'h9);
    wake(38, 50);
    stop_test(0);
  end
endmodule
